//--- design/osa_cfg.svh
// constants for the ofdm subcarrier assembler
`ifndef OSA_CFG_SVH
`define OSA_CFG_SVH

// ----------------------------------------------------------------
// symbol layout
// ----------------------------------------------------------------
`define OSA_N_FFT 128
`define OSA_N_DATA 98
`define OSA_PILOT_PERIOD 13
`define OSA_NULL_LO 52
`define OSA_NULL_HI 76
`define OSA_NEG_DATA 49

// ----------------------------------------------------------------
// scale factors, signed q1.14
// ----------------------------------------------------------------
`define OSA_K_UNITY 16'sh4000
`define OSA_K_QPSK 16'sh2d41
`define OSA_K_16QAM 16'sh143d
`define OSA_K_64QAM 16'sh09e0

// ----------------------------------------------------------------
// pilot bit generator
// ----------------------------------------------------------------
`define OSA_PRBS_W 10
`define OSA_PRBS_SEED 10'h3fe
// feedback from bits 9 and 3, gives 0001 then 1110 from the seed
`define OSA_PRBS_TAPS 10'h208

// ----------------------------------------------------------------
// phy timing
// ----------------------------------------------------------------
`define OSA_CLK_MHZ 50
`define OSA_SIFS_US 10
`define OSA_MIFS_US 2
`define OSA_SLOT_US 15
`define OSA_CCA_US 10
`define OSA_SIFS_CYC (`OSA_SIFS_US * `OSA_CLK_MHZ)
`define OSA_MIFS_CYC (`OSA_MIFS_US * `OSA_CLK_MHZ)
`define OSA_SLOT_CYC (`OSA_SLOT_US * `OSA_CLK_MHZ)
`define OSA_CCA_CYC (`OSA_CCA_US * `OSA_CLK_MHZ)

`endif

//--- design/osa_pkg.sv
// types shared by the subcarrier assembler files
package osa_pkg;
	typedef enum logic [1:0] {
		OSA_MOD_QPSK,
		OSA_MOD_16QAM,
		OSA_MOD_64QAM
	} osa_mod_t;

	typedef enum logic [1:0] {
		OSA_ST_COLLECT,
		OSA_ST_PREP,
		OSA_ST_EMIT,
		OSA_ST_GAP
	} osa_state_t;
endpackage

//--- design/osa_prbs.sv
// pilot polarity bit generator, scrambler-style lfsr
`timescale 1ns/1ps
`include "osa_cfg.svh"
module osa_prbs #(
	parameter int W = `OSA_PRBS_W,
	parameter logic [W-1:0] SEED = `OSA_PRBS_SEED,
	parameter logic [W-1:0] TAPS = `OSA_PRBS_TAPS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic step,
	output logic bit_out
);
	logic [W-1:0] state_ff;
	logic fb;

	assign fb = ^(state_ff & TAPS);
	assign bit_out = fb;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= SEED;
		end else if (load) begin
			state_ff <= SEED;
		end else if (step) begin
			state_ff <= {state_ff[W-2:0], fb};
		end
	end
endmodule // osa_prbs

//--- design/osa_pilot_table.sv
// pilot subcarrier positions for symbol index modulo 13
`timescale 1ns/1ps
module osa_pilot_table (
	input wire logic [3:0] phase,
	output logic signed [7:0] pos0,
	output logic signed [7:0] pos1,
	output logic signed [7:0] pos2,
	output logic signed [7:0] pos3
);
	logic [31:0] row;

	// four ascending positions packed, lowest in the top byte
	assign row = (phase == 4'h0) ? {8'shcd, 8'she7, 8'sh01, 8'sh1b} :
		(phase == 4'h1) ? {8'shd9, 8'shf3, 8'sh0d, 8'sh27} :
		(phase == 4'h2) ? {8'she1, 8'shfb, 8'sh15, 8'sh2f} :
		(phase == 4'h3) ? {8'shd3, 8'shed, 8'sh07, 8'sh21} :
		(phase == 4'h4) ? {8'shdd, 8'shf7, 8'sh11, 8'sh2b} :
		(phase == 4'h5) ? {8'she5, 8'shff, 8'sh19, 8'sh33} :
		(phase == 4'h6) ? {8'shcf, 8'she9, 8'sh03, 8'sh1d} :
		(phase == 4'h7) ? {8'shd7, 8'shf1, 8'sh0b, 8'sh25} :
		(phase == 4'h8) ? {8'shdf, 8'shf9, 8'sh13, 8'sh2d} :
		(phase == 4'h9) ? {8'shd1, 8'sheb, 8'sh05, 8'sh1f} :
		(phase == 4'ha) ? {8'she3, 8'shfd, 8'sh17, 8'sh31} :
		(phase == 4'hb) ? {8'shdb, 8'shf5, 8'sh0f, 8'sh29} :
		{8'shd5, 8'shef, 8'sh09, 8'sh23};
	assign pos0 = row[31:24];
	assign pos1 = row[23:16];
	assign pos2 = row[15:8];
	assign pos3 = row[7:0];
endmodule // osa_pilot_table

//--- design/osa_assembler.sv
// ofdm subcarrier assembler: data, pilots and nulls into ifft order
`timescale 1ns/1ps
`include "osa_cfg.svh"
module osa_assembler
	import osa_pkg::*;
#(
	parameter int DIN_W = 4,
	parameter int DOUT_W = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic burst_mode,
	input wire logic din_valid,
	output logic din_ready,
	input wire logic signed [DIN_W-1:0] din_re,
	input wire logic signed [DIN_W-1:0] din_im,
	input wire osa_mod_t din_mod,
	output logic dout_valid,
	input wire logic dout_ready,
	output logic signed [DOUT_W-1:0] dout_re,
	output logic signed [DOUT_W-1:0] dout_im,
	output logic [6:0] dout_idx,
	output logic dout_last,
	output logic gap_busy
);
	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [6:0] LAST_DATA = 7'(`OSA_N_DATA - 1);
	localparam logic [6:0] LAST_IDX = 7'(`OSA_N_FFT - 1);
	localparam logic [6:0] NULL_LO = 7'(`OSA_NULL_LO);
	localparam logic [6:0] NULL_HI = 7'(`OSA_NULL_HI);
	localparam logic [6:0] NEG_DATA = 7'(`OSA_NEG_DATA);
	localparam logic [3:0] LAST_PHASE = 4'(`OSA_PILOT_PERIOD - 1);
	localparam logic [9:0] SIFS_CYC = 10'(`OSA_SIFS_CYC);
	localparam logic [9:0] MIFS_CYC = 10'(`OSA_MIFS_CYC);
	localparam logic [9:0] SLOT_CYC = 10'(`OSA_SLOT_CYC);
	localparam logic [9:0] CCA_CYC = 10'(`OSA_CCA_CYC);

	// ----------------------------------------------------------------
	// scaling
	// ----------------------------------------------------------------
	function automatic logic signed [DOUT_W-1:0] scale(
		input logic signed [DIN_W-1:0] c,
		input osa_mod_t m
	);
		logic signed [15:0] f;
		logic signed [DIN_W+15:0] p;
		f = (m == OSA_MOD_QPSK) ? `OSA_K_QPSK :
			(m == OSA_MOD_16QAM) ? `OSA_K_16QAM : `OSA_K_64QAM;
		p = c * f;
		scale = p[DOUT_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	osa_state_t state_ff;
	logic [6:0] cnt_ff;
	logic [6:0] idx_ff;
	logic [6:0] dptr_ff;
	logic [3:0] phase_ff;
	logic [1:0] prep_ff;
	logic [3:0] pbits_ff;
	logic end_pend_ff;
	logic [9:0] gap_ff;
	logic signed [DOUT_W-1:0] buf_re_ff [`OSA_N_DATA];
	logic signed [DOUT_W-1:0] buf_im_ff [`OSA_N_DATA];
	logic din_ready_ff;
	logic dout_valid_ff;
	logic signed [DOUT_W-1:0] dout_re_ff;
	logic signed [DOUT_W-1:0] dout_im_ff;
	logic [6:0] dout_idx_ff;
	logic dout_last_ff;
	logic gap_busy_ff;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic accept;
	logic advance;
	logic emit;
	logic restart;
	logic signed [7:0] sc;
	logic is_null;
	logic signed [7:0] pos0;
	logic signed [7:0] pos1;
	logic signed [7:0] pos2;
	logic signed [7:0] pos3;
	logic [3:0] pil_hit;
	logic is_pilot;
	logic pil_bit;
	logic prbs_bit;
	logic prbs_step;
	logic signed [DOUT_W-1:0] val_re;
	logic signed [DOUT_W-1:0] val_im;
	logic [9:0] gap_len;

	assign accept = din_valid && din_ready_ff;
	assign advance = !dout_valid_ff || dout_ready;
	assign emit = (state_ff == OSA_ST_EMIT) && advance;
	// reload only between symbols, never mid-collection
	assign restart = frame_start && (state_ff == OSA_ST_COLLECT) &&
		(cnt_ff == 7'h00) && !accept;
	assign prbs_step = (state_ff == OSA_ST_PREP);

	// ifft input to subcarrier number
	assign sc = (idx_ff < NULL_LO) ? $signed({1'b0, idx_ff}) :
		$signed({1'b0, idx_ff}) - 8'sd64 - 8'sd64;
	assign is_null = (idx_ff == 7'h00) ||
		((idx_ff >= NULL_LO) && (idx_ff <= NULL_HI));

	assign pil_hit = {sc == pos3, sc == pos2, sc == pos1, sc == pos0};
	assign is_pilot = !is_null && (pil_hit != 4'h0);
	assign pil_bit = |(pil_hit & pbits_ff);
	assign gap_len = burst_mode ? MIFS_CYC : SIFS_CYC;

	// bit 0 maps to +1, bit 1 to -1
	assign val_re = is_null ? '0 :
		is_pilot ? (pil_bit ? -`OSA_K_UNITY : `OSA_K_UNITY) :
		buf_re_ff[dptr_ff];
	assign val_im = (is_null || is_pilot) ? '0 : buf_im_ff[dptr_ff];

	// ----------------------------------------------------------------
	// pilot schedule and bit source
	// ----------------------------------------------------------------
	osa_pilot_table u_table (
		.phase(phase_ff),
		.pos0(pos0),
		.pos1(pos1),
		.pos2(pos2),
		.pos3(pos3)
	);

	osa_prbs u_prbs (
		.clk(clk),
		.nrst(nrst),
		.load(restart),
		.step(prbs_step),
		.bit_out(prbs_bit)
	);

	// ----------------------------------------------------------------
	// data buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (accept) begin
			buf_re_ff[cnt_ff] <= scale(din_re, din_mod);
			buf_im_ff[cnt_ff] <= scale(din_im, din_mod);
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= OSA_ST_COLLECT;
		end else begin
			unique case (state_ff)
				OSA_ST_COLLECT: begin
					if (accept && cnt_ff == LAST_DATA) begin
						state_ff <= OSA_ST_PREP;
					end
				end
				OSA_ST_PREP: begin
					if (prep_ff == 2'h3) begin
						state_ff <= OSA_ST_EMIT;
					end
				end
				OSA_ST_EMIT: begin
					if (emit && idx_ff == LAST_IDX) begin
						state_ff <= end_pend_ff ? OSA_ST_GAP :
							OSA_ST_COLLECT;
					end
				end
				OSA_ST_GAP: begin
					if (gap_ff == 10'h001) begin
						state_ff <= OSA_ST_COLLECT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 7'h00;
		end else if (accept) begin
			cnt_ff <= (cnt_ff == LAST_DATA) ? 7'h00 : cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			din_ready_ff <= 1'b0;
		end else begin
			// stay closed until the last output of a symbol is taken
			din_ready_ff <= (state_ff == OSA_ST_COLLECT) &&
				!(accept && cnt_ff == LAST_DATA) &&
				!(dout_valid_ff && !dout_ready);
		end
	end

	// four fresh pilot bits per symbol, first bit to lowest carrier
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prep_ff <= 2'h0;
			pbits_ff <= 4'h0;
		end else if (prbs_step) begin
			prep_ff <= prep_ff + 2'h1;
			pbits_ff <= {prbs_bit, pbits_ff[3:1]};
		end
	end

	// symbol index modulo 13, zero at first post-preamble symbol
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_ff <= 4'h0;
		end else if (restart) begin
			phase_ff <= 4'h0;
		end else if (emit && idx_ff == LAST_IDX) begin
			phase_ff <= (phase_ff == LAST_PHASE) ? 4'h0 :
				phase_ff + 4'h1;
		end
	end

	// positive carriers follow the 49 negative data points
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idx_ff <= 7'h00;
			dptr_ff <= NEG_DATA;
		end else if (emit) begin
			idx_ff <= idx_ff + 7'h01;
			if (idx_ff == NULL_HI) begin
				dptr_ff <= 7'h00;
			end else if (idx_ff == LAST_IDX) begin
				dptr_ff <= NEG_DATA;
			end else if (!is_null && !is_pilot) begin
				dptr_ff <= dptr_ff + 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			end_pend_ff <= 1'b0;
		end else if (frame_end) begin
			end_pend_ff <= 1'b1;
		end else if (state_ff == OSA_ST_GAP) begin
			end_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_ff <= 10'h000;
		end else if (emit && idx_ff == LAST_IDX) begin
			gap_ff <= gap_len;
		end else if (gap_ff != 10'h000) begin
			gap_ff <= gap_ff - 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dout_valid_ff <= 1'b0;
			dout_re_ff <= '0;
			dout_im_ff <= '0;
			dout_idx_ff <= 7'h00;
			dout_last_ff <= 1'b0;
		end else if (advance) begin
			dout_valid_ff <= emit;
			dout_re_ff <= emit ? val_re : '0;
			dout_im_ff <= emit ? val_im : '0;
			dout_idx_ff <= idx_ff;
			// marks the tail that the prefix stage copies forward
			dout_last_ff <= emit && idx_ff == LAST_IDX;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_busy_ff <= 1'b0;
		end else begin
			gap_busy_ff <= (state_ff == OSA_ST_GAP);
		end
	end

	assign din_ready = din_ready_ff;
	assign dout_valid = dout_valid_ff;
	assign dout_re = dout_re_ff;
	assign dout_im = dout_im_ff;
	assign dout_idx = dout_idx_ff;
	assign dout_last = dout_last_ff;
	assign gap_busy = gap_busy_ff;
endmodule // osa_assembler

//--- sim/osa_ifft_sink.sv
// downstream ifft stage model for the assembler bench
`timescale 1ns/1ps
module osa_ifft_sink (
	input wire logic clk,
	input wire logic nrst,
	input wire logic stall,
	output logic dout_ready
);
	// when stalling, refuses about one cycle in four
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dout_ready <= 1'b0;
		else
			dout_ready <= !stall || ($urandom_range(3) != 0);
	end
endmodule // osa_ifft_sink

//--- sim/osa_assembler_chk.sv
// port-level checker for the subcarrier assembler
`timescale 1ns/1ps
`include "osa_cfg.svh"
module osa_assembler_chk
	import osa_pkg::*;
#(
	parameter int DIN_W = 4,
	parameter int DOUT_W = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic burst_mode,
	input wire logic din_valid,
	input wire logic din_ready,
	input wire logic signed [DIN_W-1:0] din_re,
	input wire logic signed [DIN_W-1:0] din_im,
	input wire osa_mod_t din_mod,
	input wire logic dout_valid,
	input wire logic dout_ready,
	input wire logic signed [DOUT_W-1:0] dout_re,
	input wire logic signed [DOUT_W-1:0] dout_im,
	input wire logic [6:0] dout_idx,
	input wire logic dout_last,
	input wire logic gap_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire tk = din_valid && din_ready;
	wire otk = dout_valid && dout_ready;
	logic [6:0] tcnt_ff;
	logic [9:0] gcnt_ff;
	logic bm_ff;
	wire [6:0] nxt_tcnt = !tk ? tcnt_ff : (tcnt_ff == 7'h61 ? 7'h00 : tcnt_ff + 7'h01);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tcnt_ff <= 7'h00;
			gcnt_ff <= 10'h000;
			bm_ff <= 1'b0;
		end else begin
			tcnt_ff <= nxt_tcnt;
			gcnt_ff <= gap_busy ? gcnt_ff + 10'h001 : 10'h000;
			bm_ff <= (otk && dout_last) ? burst_mode : bm_ff;
		end
	end
	property p_ready_drop;
		tk && tcnt_ff == 7'h61 |=> !din_ready [*4];
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready after 98th point");
	property p_first_out;
		tk && tcnt_ff == 7'h61 |-> ##6
			dout_valid && dout_idx == 7'h00;
	endproperty
	a_first_out: assert property (p_first_out) else $error("symbol output late");
	property p_hold;
		dout_valid && !dout_ready |=> dout_valid && $stable(dout_idx) && $stable(dout_re) && $stable(dout_im);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed while held");
	property p_idx_step;
		otk && !dout_last |=> dout_valid && dout_idx == $past(dout_idx) + 7'h01;
	endproperty
	a_idx_step: assert property (p_idx_step) else $error("index not ascending");
	property p_last;
		dout_valid |-> dout_last == (dout_idx == 7'h7f);
	endproperty
	a_last: assert property (p_last) else $error("last flag misplaced");
	property p_null;
		dout_valid && (dout_idx == 7'h00 || dout_idx inside {[7'h34:7'h4c]}) |-> dout_re == 0 && dout_im == 0;
	endproperty
	a_null: assert property (p_null) else $error("null input not zero");
	property p_gap_ready;
		gap_busy || dout_valid |-> !din_ready;
	endproperty
	a_gap_ready: assert property (p_gap_ready) else $error("ready while busy");
	property p_gap_len;
		$fell(gap_busy) |-> gcnt_ff == (bm_ff ? `OSA_MIFS_CYC : `OSA_SIFS_CYC);
	endproperty
	a_gap_len: assert property (p_gap_len) else $error("gap length wrong");
	c_stall: cover property (dout_valid && !dout_ready);
	c_burst_gap: cover property ($fell(gap_busy) && bm_ff);
	c_short_gap: cover property ($fell(gap_busy) && !bm_ff);
endmodule // osa_assembler_chk

//--- sim/ofdm_subcarrier_assembler_tb_top.sv
// self-checking bench for the subcarrier assembler
`timescale 1ns/1ps
`include "osa_cfg.svh"
module ofdm_subcarrier_assembler_tb_top;
	import osa_pkg::*;
	typedef struct {logic [6:0] idx; logic signed [15:0] re, im; bit any;} osa_exp_t;
	logic clk, nrst, frame_start, frame_end, burst_mode, din_valid, din_ready;
	logic signed [3:0] din_re, din_im;
	osa_mod_t din_mod;
	logic dout_valid, dout_ready, dout_last, gap_busy, stall;
	logic signed [15:0] dout_re, dout_im;
	logic [6:0] dout_idx;
	osa_exp_t q[$];
	int fail_count, samples_checked, gap_len;
	int pt[4][13] = '{'{-51,-39,-31,-45,-35,-27,-49,-41,-33,-47,-29,-37,-43},
		'{-25,-13,-5,-19,-9,-1,-23,-15,-7,-21,-3,-11,-17},
		'{1,13,21,7,17,25,3,11,19,5,23,15,9},
		'{27,39,47,33,43,51,29,37,45,31,49,41,35}};
	osa_assembler u_osa_assembler (.clk(clk), .nrst(nrst),
		.frame_start(frame_start), .frame_end(frame_end),
		.burst_mode(burst_mode), .din_valid(din_valid), .din_ready(din_ready),
		.din_re(din_re), .din_im(din_im), .din_mod(din_mod),
		.dout_valid(dout_valid), .dout_ready(dout_ready), .dout_re(dout_re),
		.dout_im(dout_im), .dout_idx(dout_idx), .dout_last(dout_last),
		.gap_busy(gap_busy));
	osa_ifft_sink u_osa_ifft_sink (.clk(clk), .nrst(nrst), .stall(stall),
		.dout_ready(dout_ready));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic mismatch(input string m);
		$display("wrong value at %0t: %s", $time, m);
		fail_count++;
	endtask
	task automatic final_report();
		$display("checked %0d, wrong %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp_out(input osa_exp_t e);
		samples_checked++;
		if (dout_idx !== e.idx || dout_im !== e.im || dout_last !== (e.idx == 7'h7f)
			|| (e.any ? (dout_re !== 16'sh4000 && dout_re !== -16'sh4000) : dout_re !== e.re))
			mismatch($sformatf("idx %0d re %0d exp %0d", dout_idx, dout_re, e.re));
	endtask
	task automatic cmp_gap(input int got, input int exp);
		samples_checked++;
		if (got != exp)
			mismatch($sformatf("gap %0d exp %0d", got, exp));
	endtask
	// ---------------------------------------------------------------
	// output watchers
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (nrst && dout_valid === 1'b1 && dout_ready === 1'b1) begin
			if (q.size() == 0)
				mismatch("unexpected output");
			else
				cmp_out(q.pop_front());
		end
		if (gap_busy === 1'b1)
			gap_len <= gap_len + 1;
		else if (gap_len != 0) begin
			cmp_gap(gap_len, burst_mode ? `OSA_MIFS_CYC : `OSA_SIFS_CYC);
			gap_len <= 0;
		end
	end
	// ---------------------------------------------------------------
	// upstream driver
	// ---------------------------------------------------------------
	task automatic wait_ready();
		int t;
		t = 0;
		@(negedge clk);
		while (din_ready !== 1'b1) begin
			if (++t > 3000) begin
				mismatch("ready wait ran out");
				final_report();
			end
			@(negedge clk);
		end
	endtask
	function automatic logic signed [15:0] kof(input osa_mod_t m);
		kof = m == OSA_MOD_QPSK ? `OSA_K_QPSK : m == OSA_MOD_16QAM ? `OSA_K_16QAM : `OSA_K_64QAM;
	endfunction
	task automatic send_symbol(input int s, input bit fe, input bit xs);
		int n, b, k;
		logic signed [15:0] vr[-76:51];
		bit pil[-76:51];
		logic signed [3:0] pr[98], pq[98];
		osa_mod_t pm[98];
		osa_exp_t e;
		vr = '{default:0};
		pil = '{default:0};
		for (int j = 0; j < 4; j++)
			pil[pt[j][s % 13]] = 1;
		n = 0;
		b = 0;
		for (k = -51; k <= 51; k++) begin
			if (k != 0 && pil[k]) begin
				vr[k] = ((s == 0) ? (b == 3) : (b != 3)) ? -16'sh4000 : 16'sh4000;
				b++;
			end else if (k != 0) begin
				pm[n] = osa_mod_t'($urandom_range(2));
				pr[n] = 4'(2 * $urandom_range((1 << int'(pm[n])) - 1) + 1);
				pq[n] = 4'(2 * $urandom_range((1 << int'(pm[n])) - 1) + 1);
				if ($urandom_range(1)) pr[n] = -pr[n];
				if ($urandom_range(1)) pq[n] = -pq[n];
				vr[k] = pr[n] * kof(pm[n]);
				n++;
			end
		end
		for (int i = 0; i < 128; i++) begin
			k = i <= 51 ? i : i - 128;
			e.idx = 7'(i);
			e.re = vr[k];
			e.im = (k == 0 || pil[k] || k < -51) ? 16'sh0000 : 16'sh0000;
			e.any = pil[k] && s >= 2;
			q.push_back(e);
		end
		n = 0;
		for (k = -51; k <= 51; k++)
			if (k != 0 && !pil[k]) begin
				q[q.size() - 128 + (k > 0 ? k : k + 128)].im = pq[n] * kof(pm[n]);
				n++;
			end
		for (n = 0; n < 98; n++) begin
			din_valid <= 1'b1;
			din_re <= pr[n];
			din_im <= pq[n];
			din_mod <= pm[n];
			wait_ready();
			@(posedge clk);
		end
		din_valid <= 1'b0;
		frame_end <= fe;
		frame_start <= xs;
		@(posedge clk);
		frame_end <= 1'b0;
		frame_start <= 1'b0;
	endtask
	task automatic run_frame(input int ns, input bit bm, input bit xs);
		wait_ready();
		repeat (3) @(posedge clk);
		burst_mode <= bm;
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		for (int s = 0; s < ns; s++)
			send_symbol(s, s == ns - 1, xs && s == 0);
	endtask
	initial begin
		void'($urandom(32'hb951));
		{nrst, frame_start, frame_end, burst_mode, din_valid} = 5'h00;
		{din_re, din_im} = 8'h00;
		din_mod = OSA_MOD_QPSK;
		stall = 1'b1;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		run_frame(14, 1'b0, 1'b0);
		$display("test 1 done: 14 symbols, stalls, short gap");
		stall <= 1'b0;
		run_frame(2, 1'b1, 1'b1);
		$display("test 2 done: reload, ignored restart, burst gap");
		wait_ready();
		repeat (4) @(posedge clk);
		if (q.size() != 0)
			mismatch("outputs missing");
		final_report();
	end
endmodule // ofdm_subcarrier_assembler_tb_top
bind osa_assembler osa_assembler_chk #(.DIN_W(DIN_W), .DOUT_W(DOUT_W))
	u_osa_assembler_chk (.clk(clk), .nrst(nrst), .frame_start(frame_start),
	.frame_end(frame_end), .burst_mode(burst_mode), .din_valid(din_valid),
	.din_ready(din_ready), .din_re(din_re), .din_im(din_im),
	.din_mod(din_mod), .dout_valid(dout_valid), .dout_ready(dout_ready),
	.dout_re(dout_re), .dout_im(dout_im), .dout_idx(dout_idx),
	.dout_last(dout_last), .gap_busy(gap_busy));
